// ### src/adcsr_pkg.sv
// package of constants for the id and status register bank
// assumes a 32-bit avalon-mm slave with word addressing by index
package adcsr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DEVICE_IDENTIFICATION = 4'h0;
  localparam logic [3:0] IDX_DEVICE_STATUS = 4'h1;
  localparam logic [3:0] IDX_MODE_CONTROL = 4'h2;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h3;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h4;
  localparam logic [3:0] IDX_EVENT_CONTROL = 4'h5;

  // ----------------------------------------------------------------
  // identification fields
  // ----------------------------------------------------------------
  localparam int ID_UPPER_POS = 12;
  localparam int ID_CHAN_COUNT_POS = 8;
  localparam logic [3:0] ID_UPPER_VAL = 4'h5; // arbitrary value
  localparam logic [7:0] ID_LOW_VAL = 8'h3c; // arbitrary value
  localparam logic [3:0] CHAN_COUNT = 4'h8;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_LOCK = 15;
  localparam int ST_RESYNC = 14;
  localparam int ST_REGMAP = 13;
  localparam int ST_CRCERR = 12;
  localparam int ST_CRCTYPE = 11;
  localparam int ST_RESET = 10;
  localparam int ST_WLEN_POS = 8;
  localparam logic [15:0] STATUS_RESET = 16'h0500;

  // ----------------------------------------------------------------
  // mode control fields and reset values
  // ----------------------------------------------------------------
  localparam int MD_CRCTYPE = 11;
  localparam int MD_RESET = 10;
  localparam int MD_WLEN_POS = 8;
  localparam logic [1:0] WLEN_RESET = 2'h1;
  localparam logic CRCTYPE_RESET = 1'b0;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_RESYNC = 0;
  localparam int IRQ_REGMAP = 1;
  localparam int IRQ_CRCERR = 2;
  localparam int IRQ_NEWDATA = 3;
  localparam int IRQ_WIDTH = 4;

  // ----------------------------------------------------------------
  // event control: write one to clear sticky status flags
  // ----------------------------------------------------------------
  localparam int EV_CLR_RESYNC = 0;
  localparam int EV_CLR_REGMAP = 1;
  localparam int EV_CLR_CRCERR = 2;

endpackage

// ### src/adcsr_sync.sv
// two-flop synchroniser for a vector of levels
// assumes inputs come from outside the ref_clk domain
module adcsr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // two stages, the first read by the second only
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### src/adcsr_flags.sv
// sticky event flags: set by a pulse, cleared by a clear strobe
// assumes pulses and clears are in the ref_clk domain
module adcsr_flags #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clr_pulse,
  output logic [WIDTH-1:0] flag_q
);

  logic [WIDTH-1:0] flag_d;

  // set wins over a clear in the same cycle
  assign flag_d = (flag_q & ~clr_pulse) | set_pulse;

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// ### src/adcsr_regs.sv
// id and status register bank of an eight-channel converter
// assumes an avalon-mm master on ref_clk and asynchronous event inputs
// ----------------------------------------------------------------
// Summary of operation
// - id word: channel count, opaque low byte
// - id word at index zero, read only
// - status at index one, resets 0500
// - bit 15 shows serial lock level
// - bit 14 set on each resync
// - bit 13 set on register checksum change
// - bit 12 set on input frame checksum error
// - bit 11 shows checksum polynomial type
// - bit 10 reset-occurred flag, set at reset
// - bits 9:8 show data word length
// - bits 7:0 per-channel new-data flags
//
// Chosen here: the Avalon-MM slave port.
module adcsr_regs #(
  parameter int NUM_CHAN = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  input wire logic serial_lock_in,
  input wire logic converter_resync_in,
  input wire logic regmap_crc_change_in,
  input wire logic frame_crc_error_in,
  input wire logic [NUM_CHAN-1:0] new_sample_in,
  input wire logic [NUM_CHAN-1:0] sample_taken_in,
  output logic [1:0] sample_word_size,
  output logic crc_type_ansi,
  output logic irq
);

  typedef enum logic [1:0] {
    ADCSR_IDLE = 2'b01,
    ADCSR_DONE = 2'b10
  } adcsr_bus_t;

  adcsr_bus_t bus_q;
  adcsr_bus_t bus_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  logic [1:0] wlen_q;
  logic crctype_q;
  logic rstflag_q;
  logic [adcsr_pkg::IRQ_WIDTH-1:0] imask_q;
  logic [adcsr_pkg::IRQ_WIDTH-1:0] istat_q;
  logic [adcsr_pkg::IRQ_WIDTH-1:0] istat_d;
  logic [2:0] ev_s;
  logic [2:0] ev_prev_q;
  logic [2:0] ev_rise;
  logic lock_s;
  logic [NUM_CHAN-1:0] nd_s;
  logic [NUM_CHAN-1:0] nd_prev_q;
  logic [NUM_CHAN-1:0] tk_s;
  logic [NUM_CHAN-1:0] tk_prev_q;
  logic [NUM_CHAN-1:0] nd_flags;
  logic [2:0] sticky;
  logic [2:0] sticky_clr;
  logic [15:0] id_word;
  logic [15:0] status_word;
  logic [15:0] mode_word;

  // byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // event lines: 0 resync, 1 register map change, 2 frame error
  adcsr_sync #(.WIDTH(4)) u_sync_ev (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({serial_lock_in, frame_crc_error_in, regmap_crc_change_in,
               converter_resync_in}),
    .sync_out({lock_s, ev_s})
  );

  adcsr_sync #(.WIDTH(2 * NUM_CHAN)) u_sync_nd (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({sample_taken_in, new_sample_in}),
    .sync_out({tk_s, nd_s})
  );

  // rising edges of the synchronised event lines
  assign ev_rise = ev_s & ~ev_prev_q;

  // ----------------------------------------------------------------
  // sticky flags: resync, register map change, frame error, new data
  // ----------------------------------------------------------------
  adcsr_flags #(.WIDTH(3)) u_evflags (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_pulse(ev_rise),
    .clr_pulse(sticky_clr),
    .flag_q(sticky)
  );

  // new data set on edge, cleared when the sample has been taken
  adcsr_flags #(.WIDTH(NUM_CHAN)) u_ndflags (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_pulse(nd_s & ~nd_prev_q),
    .clr_pulse(tk_s & ~tk_prev_q),
    .flag_q(nd_flags)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = (avs_read | avs_write) && bus_q == ADCSR_IDLE;
  wire wr_go = avs_write && bus_q == ADCSR_IDLE;
  wire rd_go = avs_read && bus_q == ADCSR_IDLE;
  wire hit_id = avs_address == adcsr_pkg::IDX_DEVICE_IDENTIFICATION;
  wire hit_st = avs_address == adcsr_pkg::IDX_DEVICE_STATUS;
  wire hit_md = avs_address == adcsr_pkg::IDX_MODE_CONTROL;
  wire hit_is = avs_address == adcsr_pkg::IDX_IRQ_STATUS;
  wire hit_im = avs_address == adcsr_pkg::IDX_IRQ_MASK;
  wire hit_ev = avs_address == adcsr_pkg::IDX_EVENT_CONTROL;
  wire mapped = hit_id | hit_st | hit_md | hit_is | hit_im | hit_ev;
  wire wr_md = wr_go && hit_md;
  wire wr_im = wr_go && hit_im;
  wire wr_ev = wr_go && hit_ev;
  wire rd_is = rd_go && hit_is;
  wire [15:0] md_new = merge16(mode_word, avs_writedata, avs_byteenable);

  // sticky clears by write-one to the event control register
  assign sticky_clr = wr_ev && avs_byteenable[0] ?
                      avs_writedata[2:0] : 3'h0;

  // ----------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------
  // fixed id word, channel count in 11:8
  assign id_word = {adcsr_pkg::ID_UPPER_VAL, adcsr_pkg::CHAN_COUNT,
                    adcsr_pkg::ID_LOW_VAL};

  // status word, type and length mirrored from mode control
  // bit 14 resync, bit 13 register map change, bit 12 frame error
  assign status_word = {lock_s, sticky[0], sticky[1], sticky[2],
                        crctype_q, rstflag_q, wlen_q,
                        nd_flags};
  assign mode_word = {4'h0, crctype_q, rstflag_q, wlen_q, 8'h00};

  // read mux
  assign rdata_d = !mapped ? 32'h0 :
                   hit_id ? {16'h0, id_word} :
                   hit_st ? {16'h0, status_word} :
                   hit_md ? {16'h0, mode_word} :
                   hit_is ? {28'h0, istat_q} :
                   hit_im ? {28'h0, imask_q} : 32'h0;

  // one wait cycle per access, error on unmapped address
  assign bus_d = req ? ADCSR_DONE : ADCSR_IDLE;
  assign err_d = req && !mapped;

  // ----------------------------------------------------------------
  // bus handshake state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_q <= ADCSR_IDLE;
      rdata_q <= 32'h0;
      err_q <= 1'b0;
    end else begin
      case (bus_q)
        ADCSR_IDLE: bus_q <= bus_d;
        ADCSR_DONE: bus_q <= ADCSR_IDLE;
        default: bus_q <= ADCSR_IDLE;
      endcase
      rdata_q <= rd_go ? rdata_d : rdata_q;
      err_q <= err_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) && bus_q != ADCSR_DONE;
  assign avs_readdata = rdata_q;
  assign avs_response_err = err_q;

  // ----------------------------------------------------------------
  // mode control: word length, checksum type, reset flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wlen_q <= adcsr_pkg::WLEN_RESET;
      crctype_q <= adcsr_pkg::CRCTYPE_RESET;
      rstflag_q <= 1'b1;
    end else if (wr_md) begin
      wlen_q <= md_new[adcsr_pkg::MD_WLEN_POS +: 2];
      crctype_q <= md_new[adcsr_pkg::MD_CRCTYPE];
      // writing zero clears, writing one leaves it set
      rstflag_q <= rstflag_q & md_new[adcsr_pkg::MD_RESET];
    end
  end

  assign sample_word_size = wlen_q;
  assign crc_type_ansi = crctype_q;

  // ----------------------------------------------------------------
  // interrupt status, cleared by a read, and mask, loaded by a write
  // ----------------------------------------------------------------
  assign istat_d = (rd_is ? '0 : istat_q) |
                   {|(nd_s & ~nd_prev_q), ev_rise};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      istat_q <= '0;
      imask_q <= '0;
      ev_prev_q <= 3'h0;
      nd_prev_q <= '0;
      tk_prev_q <= '0;
    end else begin
      istat_q <= istat_d;
      if (wr_im && avs_byteenable[0]) begin
        imask_q <= avs_writedata[adcsr_pkg::IRQ_WIDTH-1:0];
      end
      ev_prev_q <= ev_s;
      nd_prev_q <= nd_s;
      tk_prev_q <= tk_s;
    end
  end

  assign irq = |(istat_q & imask_q);

endmodule

// ### sim/adcsr_regs_assertions.sv
// checker for the id and status register bank
// assumes binding to adcsr_regs, one clock domain
module adcsr_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err,
  input wire logic serial_lock_in,
  input wire logic [1:0] sample_word_size,
  input wire logic crc_type_ansi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // read answer cycle
  wire ans = avs_read && !avs_waitrequest;
  // bus handshake and register contents
  a_one_wait:
  assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("wait longer than one cycle");
  a_first_wait:
  assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait");
  a_idle_nowait:
  assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait while idle");
  a_id_fields:
  assert property (ans && avs_address == 4'h0 |-> avs_readdata[31:8] ==
    {16'h0, adcsr_pkg::ID_UPPER_VAL, adcsr_pkg::CHAN_COUNT})
    else $error("id word wrong");
  a_status_mirror:
  assert property (ans && avs_address == 4'h1 |->
    avs_readdata[31:16] == 16'h0 && avs_readdata[11] == crc_type_ansi
    && avs_readdata[9:8] == sample_word_size)
    else $error("status does not mirror mode");
  a_lock_level:
  assert property ($stable(serial_lock_in) [*6] ##1
    (ans && avs_address == 4'h1) |-> avs_readdata[15] == serial_lock_in)
    else $error("lock bit wrong");
  a_err_unmapped:
  assert property (ans && avs_address > 4'h5 |->
    avs_response_err && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  a_err_cause:
  assert property (avs_response_err |-> (avs_read || avs_write) &&
    avs_address > 4'h5 && !avs_waitrequest)
    else $error("error without cause");
endmodule

bind adcsr_regs adcsr_chk adcsr_chk_inst (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .serial_lock_in(serial_lock_in),
  .sample_word_size(sample_word_size), .crc_type_ansi(crc_type_ansi));

// ### sim/adcsr_host.sv
// host model: avalon-mm master reaching the register bank
// assumes the bench calls xfer only after reset is released
module adcsr_host (
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // one access, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= wd;
    avs_byteenable <= 4'h3;
    // sampled right after each rising edge, before the slave updates
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// ### sim/adcsr_regs_test.sv
// self-checking bench of the id and status register bank
// assumes adcsr_regs, adcsr_host and the bound checker are compiled
module adcsr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic serial_lock_in = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [7:0] nd = 8'h0;
  logic [7:0] tk = 8'h0;
  logic [31:0] d;
  wire [3:0] a;
  wire r, w, wq, err, irq, crc;
  wire [31:0] wd, rdat;
  wire [3:0] be;
  wire [1:0] wl;
  int error_cnt = 0;
  int n_tests = 0;
  always #20 ref_clk = ~ref_clk;
  // block under test and host model
  adcsr_regs adcsr_regs_inst (.ref_clk(ref_clk), .rst(rst),
    .avs_address(a), .avs_read(r), .avs_write(w), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .avs_response_err(err), .serial_lock_in(serial_lock_in),
    .converter_resync_in(ev[0]), .regmap_crc_change_in(ev[1]),
    .frame_crc_error_in(ev[2]), .new_sample_in(nd), .sample_taken_in(tk),
    .sample_word_size(wl), .crc_type_ansi(crc), .irq(irq));
  adcsr_host adcsr_host_inst (.ref_clk(ref_clk), .avs_waitrequest(wq),
    .avs_readdata(rdat), .avs_address(a), .avs_read(r), .avs_write(w),
    .avs_writedata(wd), .avs_byteenable(be));
  // compare, bus and wait helpers
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] adr);
    adcsr_host_inst.xfer(1'b0, adr, 32'h0, d);
  endtask
  task automatic wr(input logic [3:0] adr, input logic [31:0] v);
    adcsr_host_inst.xfer(1'b1, adr, v, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reset values, id fields, writes to read-only words ignored
  task automatic t_id;
    rd(4'h1);
    chk(d, 32'h0500, "status reset");
    chk({30'h0, wl}, 32'h1, "length port");
    wr(4'h0, 32'hffff);
    wr(4'h1, 32'hffff);
    rd(4'h0);
    chk(d & 32'hffffff00, {16'h0, adcsr_pkg::ID_UPPER_VAL,
      adcsr_pkg::CHAN_COUNT, 8'h0}, "id word");
    rd(4'h1);
    chk(d, 32'h0500, "status after write");
    $display("id test done");
  endtask
  // lock level follows the input
  task automatic t_lock;
    serial_lock_in <= 1'b1;
    cyc(6);
    rd(4'h1);
    chk(d, 32'h8500, "locked");
    serial_lock_in <= 1'b0;
    cyc(6);
    rd(4'h1);
    chk(d, 32'h0500, "unlocked");
    $display("lock test done");
  endtask
  // sticky event flags, interrupt, clear and a second resync
  task automatic t_ev;
    wr(4'h4, 32'hf);
    @(posedge ref_clk);
    ev <= 3'h7;
    cyc(3);
    ev <= 3'h0;
    cyc(8);
    rd(4'h1);
    chk(d, 32'h7500, "event flags");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(4'h3);
    chk(d, 32'h7, "irq status");
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(4'h5, 32'h7);
    @(posedge ref_clk);
    ev <= 3'h1;
    cyc(3);
    ev <= 3'h0;
    cyc(8);
    rd(4'h1);
    chk(d, 32'h4500, "second resync");
    wr(4'h5, 32'h7);
    rd(4'h3);
    chk(d, 32'h1, "resync irq");
    $display("event test done");
  endtask
  // every word length and checksum type, reset flag cleared by zero
  task automatic t_mode;
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {20'h0, i[2], 1'b0, i[1:0], 8'h0};
      wr(4'h2, v);
      rd(4'h1);
      chk(d, v, "mode mirror");
      chk({30'h0, wl}, {30'h0, i[1:0]}, "length");
      chk({31'h0, crc}, {31'h0, i[2]}, "type port");
    end
    wr(4'h2, 32'h0100);
    $display("mode test done");
  endtask
  // per-channel new-data flags set one by one, then all taken
  task automatic t_data;
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk);
      nd <= 8'h1 << c;
      cyc(3);
      nd <= 8'h0;
      cyc(8);
      rd(4'h1);
      chk(d, 32'h0100 | ((32'h2 << c) - 1), "new data");
    end
    rd(4'h3);
    chk(d, 32'h8, "data irq");
    tk <= 8'hff;
    cyc(3);
    tk <= 8'h0;
    cyc(8);
    rd(4'h1);
    chk(d, 32'h0100, "data taken");
    $display("data test done");
  endtask
  // unmapped read, then reset in mid-run brings the flag back
  task automatic t_misc;
    rd(4'h9);
    chk(d, 32'h0, "unmapped");
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    rd(4'h1);
    chk(d, 32'h0500, "second reset");
    $display("misc test done");
  endtask
  // main sequence
  initial begin
    cyc(4);
    rst <= 1'b0;
    t_id;
    t_lock;
    t_ev;
    t_mode;
    t_data;
    t_misc;
    end_sim;
  end
  // watchdog against a hung handshake
  initial begin
    cyc(20000);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_sim;
  end
endmodule
